// >>> hw/pafs_top.sv
// The register addresses and register access over APB were decided locally.
`default_nettype none

// Functional notes
// - bit0 00 timer a input, 11 inverted output
// - bit2 00 driver enable, 01 reset, 10 timer b
// - bit3 cts, comparator out, timer b in, analog
// - bit4 00 receive line, 11 analog negative input
// - bit5 00 transmit line, 01 inverted timer b
// - bit5 11 analog positive input, 10 reserved
// - select applies only while function enable set
// - analog choice bypasses the digital output path
// - some pins interrupt on chosen single edge
// - other pins interrupt on both edges
// - alternate function overrides direction setting
module pafs_top
    import pafs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    output logic [5:0] analog_en,
    input wire pafs_periph_out_t periph_out,
    output pafs_periph_in_t periph_in,
    output logic irq
);

    // software-visible state
    logic [5:0] data_out_ff; // gpio output data
    logic [5:0] dir_ff; // 1 = input, 0 = output
    logic [5:0] af_en_ff; // alternate function enable per pin
    logic [5:0] fsel_low_ff; // function_select_low
    logic [5:0] fsel_high_ff; // function_select_high
    logic [5:0] edge_rise_ff; // 1 = rising edge, 0 = falling edge
    logic [5:0] irq_status_ff; // sticky pin events
    logic [5:0] irq_en_ff; // interrupt enable
    logic [31:0] prdata_ff; // read data captured in the setup phase
    logic [5:0] nxt_data_out;
    logic [5:0] nxt_dir;
    logic [5:0] nxt_af_en;
    logic [5:0] nxt_fsel_low;
    logic [5:0] nxt_fsel_high;
    logic [5:0] nxt_edge_rise;
    logic [5:0] nxt_irq_status;
    logic [5:0] nxt_irq_en;
    logic [31:0] nxt_prdata;

    // pad- and peripheral-facing registered outputs
    logic [5:0] pin_out_ff;
    logic [5:0] pin_oe_ff;
    logic [5:0] analog_en_ff;
    pafs_periph_in_t periph_in_ff;
    logic [5:0] nxt_pin_out;
    logic [5:0] nxt_pin_oe;
    logic [5:0] nxt_analog_en;
    pafs_periph_in_t nxt_periph_in;

    // synchronised pins
    logic [5:0] pin_level; // accepted pin levels
    logic [5:0] pin_rise; // one-cycle rising pulses
    logic [5:0] pin_fall; // one-cycle falling pulses
    logic [5:0] pin_event; // qualified interrupt events

    // bus decode
    logic wr_en; // write completes this edge
    logic addr_ok; // address hits a mapped register
    logic [5:0] clr_mask; // bits cleared by a write to irq_clear

    // every pin passes the same three-stage chain
    genvar gi;
    generate
        for (gi = 0; gi < PAFS_PINS; gi++)
        begin : g_sync
            pafs_sync u_sync
            (
                .clock(clock),
                .rstn(rstn),
                .async_in(pin_in[gi]),
                .level(pin_level[gi]),
                .rise(pin_rise[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;

    // address decode for the error answer only; reads and writes decode paddr themselves
    always_comb
    begin
        unique case (paddr)
            PAFS_OFF_DATA_OUT, PAFS_OFF_DIR, PAFS_OFF_AF_EN,
            PAFS_OFF_FSEL_LOW, PAFS_OFF_FSEL_HIGH, PAFS_OFF_DATA_IN,
            PAFS_OFF_EDGE_RISE, PAFS_OFF_IRQ_STATUS, PAFS_OFF_IRQ_CLEAR,
            PAFS_OFF_IRQ_ENABLE:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error; nothing is written
    assign pslverr = psel && penable && !addr_ok;

    // register writes and read-data capture
    always_comb
    begin
        nxt_data_out = data_out_ff;
        nxt_dir = dir_ff;
        nxt_af_en = af_en_ff;
        nxt_fsel_low = fsel_low_ff;
        nxt_fsel_high = fsel_high_ff;
        nxt_edge_rise = edge_rise_ff;
        nxt_irq_en = irq_en_ff;
        clr_mask = 6'h00;
        nxt_prdata = prdata_ff;
        if (wr_en)
        begin
            unique case (paddr)
                PAFS_OFF_DATA_OUT: nxt_data_out = pwdata[5:0];
                PAFS_OFF_DIR: nxt_dir = pwdata[5:0];
                PAFS_OFF_AF_EN: nxt_af_en = pwdata[5:0];
                PAFS_OFF_FSEL_LOW: nxt_fsel_low = pwdata[5:0];
                PAFS_OFF_FSEL_HIGH: nxt_fsel_high = pwdata[5:0];
                PAFS_OFF_EDGE_RISE: nxt_edge_rise = pwdata[5:0];
                PAFS_OFF_IRQ_CLEAR: clr_mask = pwdata[5:0];
                PAFS_OFF_IRQ_ENABLE: nxt_irq_en = pwdata[5:0];
                default: clr_mask = 6'h00; // read-only or unmapped
            endcase
        end
        // read data is picked in the setup phase so it leaves a flop
        if (psel && !penable)
        begin
            unique case (paddr)
                PAFS_OFF_DATA_OUT:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, data_out_ff};
                PAFS_OFF_DIR:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, dir_ff};
                PAFS_OFF_AF_EN:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, af_en_ff};
                PAFS_OFF_FSEL_LOW:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, fsel_low_ff};
                PAFS_OFF_FSEL_HIGH:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, fsel_high_ff};
                PAFS_OFF_DATA_IN:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, pin_level};
                PAFS_OFF_EDGE_RISE:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, edge_rise_ff};
                PAFS_OFF_IRQ_STATUS:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, irq_status_ff};
                PAFS_OFF_IRQ_ENABLE:
                    nxt_prdata = {{PAFS_PAD_W{1'b0}}, irq_en_ff};
                default:
                    nxt_prdata = 32'h0000_0000; // clear reg and holes
            endcase
        end
    end

    // interrupt events; a pin edge in the clearing cycle still sets
    always_comb
    begin
        for (int i = 0; i < PAFS_PINS; i++)
        begin
            if (PAFS_EDGE_CFG_MASK[i])
                pin_event[i] = edge_rise_ff[i] ? pin_rise[i]
                                               : pin_fall[i];
            else
                pin_event[i] = pin_rise[i] | pin_fall[i];
        end
        nxt_irq_status = (irq_status_ff & ~clr_mask) | pin_event;
    end

    // level interrupt while any enabled event is pending
    assign irq = |(irq_status_ff & irq_en_ff);

    // register file flops
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            data_out_ff <= PAFS_RST_DATA_OUT;
            dir_ff <= PAFS_RST_DIR;
            af_en_ff <= PAFS_RST_AF_EN;
            fsel_low_ff <= PAFS_RST_FSEL;
            fsel_high_ff <= PAFS_RST_FSEL;
            edge_rise_ff <= PAFS_RST_EDGE_RISE;
            irq_status_ff <= PAFS_RST_IRQ;
            irq_en_ff <= PAFS_RST_IRQ;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            data_out_ff <= nxt_data_out;
            dir_ff <= nxt_dir;
            af_en_ff <= nxt_af_en;
            fsel_low_ff <= nxt_fsel_low;
            fsel_high_ff <= nxt_fsel_high;
            edge_rise_ff <= nxt_edge_rise;
            irq_status_ff <= nxt_irq_status;
            irq_en_ff <= nxt_irq_en;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

    // pin mux: gpio by default, alternate function when enabled;
    // reserved codes release the pad rather than guess a function
    always_comb
    begin
        pafs_sel_t sel;
        sel = PAFS_SEL_00;
        nxt_pin_out = data_out_ff;
        nxt_pin_oe = ~dir_ff;
        nxt_analog_en = 6'h00;
        nxt_periph_in = PAFS_PERIPH_IN_IDLE;
        for (int i = 0; i < PAFS_PINS; i++)
        begin
            if (af_en_ff[i])
            begin
                sel = pafs_sel_t'({fsel_low_ff[i], fsel_high_ff[i]});
                // the function owns the driver, not the direction bit
                nxt_pin_out[i] = 1'b0;
                nxt_pin_oe[i] = 1'b0;
                unique case (i)
                    0:
                        unique case (sel)
                            PAFS_SEL_00:
                                nxt_periph_in.timer_a_input =
                                    pin_level[0];
                            PAFS_SEL_11:
                            begin
                                nxt_pin_out[0] =
                                    ~periph_out.timer_a_output;
                                nxt_pin_oe[0] = 1'b1;
                            end
                            default: nxt_pin_oe[0] = 1'b0;
                        endcase
                    1:
                        unique case (sel)
                            PAFS_SEL_00:
                            begin
                                nxt_pin_out[1] =
                                    periph_out.timer_a_output;
                                nxt_pin_oe[1] = 1'b1;
                            end
                            PAFS_SEL_10:
                                nxt_periph_in.external_clock_input =
                                    pin_level[1];
                            PAFS_SEL_11:
                                nxt_analog_en[1] = 1'b1;
                            default: nxt_pin_oe[1] = 1'b0;
                        endcase
                    2:
                        unique case (sel)
                            PAFS_SEL_00:
                            begin
                                nxt_pin_out[2] =
                                    periph_out.uart_driver_enable;
                                nxt_pin_oe[2] = 1'b1;
                            end
                            PAFS_SEL_01:
                                nxt_periph_in.external_reset_input =
                                    pin_level[2];
                            PAFS_SEL_10:
                            begin
                                nxt_pin_out[2] =
                                    periph_out.timer_b_output;
                                nxt_pin_oe[2] = 1'b1;
                            end
                            default: nxt_pin_oe[2] = 1'b0;
                        endcase
                    3:
                        unique case (sel)
                            PAFS_SEL_00:
                                nxt_periph_in.uart_clear_to_send =
                                    pin_level[3];
                            PAFS_SEL_01:
                            begin
                                nxt_pin_out[3] =
                                    periph_out.comparator_output;
                                nxt_pin_oe[3] = 1'b1;
                            end
                            PAFS_SEL_10:
                                nxt_periph_in.timer_b_input =
                                    pin_level[3];
                            PAFS_SEL_11:
                                nxt_analog_en[3] = 1'b1;
                        endcase
                    4:
                        unique case (sel)
                            PAFS_SEL_00:
                                nxt_periph_in.uart_receive_line =
                                    pin_level[4];
                            PAFS_SEL_11:
                                nxt_analog_en[4] = 1'b1;
                            default: nxt_pin_oe[4] = 1'b0;
                        endcase
                    default:
                        unique case (sel)
                            PAFS_SEL_00:
                            begin
                                nxt_pin_out[5] =
                                    periph_out.uart_transmit_line;
                                nxt_pin_oe[5] = 1'b1;
                            end
                            PAFS_SEL_01:
                            begin
                                nxt_pin_out[5] =
                                    ~periph_out.timer_b_output;
                                nxt_pin_oe[5] = 1'b1;
                            end
                            PAFS_SEL_11:
                                nxt_analog_en[5] = 1'b1;
                            default: nxt_pin_oe[5] = 1'b0;
                        endcase
                endcase
            end
        end
    end

    // pad and peripheral side flops, one cycle behind the mux
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_out_ff <= 6'h00;
            pin_oe_ff <= 6'h00;
            analog_en_ff <= 6'h00;
            periph_in_ff <= PAFS_PERIPH_IN_IDLE;
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            analog_en_ff <= nxt_analog_en;
            periph_in_ff <= nxt_periph_in;
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign analog_en = analog_en_ff;
    assign periph_in = periph_in_ff;

endmodule // pafs_top

`default_nettype wire

// >>> hw/pafs_pkg.sv
`default_nettype none

package pafs_pkg;

    // number of port a pins bonded out on the small package
    localparam int PAFS_PINS = 6;

    // apb register byte offsets
    localparam logic [11:0] PAFS_OFF_DATA_OUT = 12'h000;
    localparam logic [11:0] PAFS_OFF_DIR = 12'h004;
    localparam logic [11:0] PAFS_OFF_AF_EN = 12'h008;
    localparam logic [11:0] PAFS_OFF_FSEL_LOW = 12'h00c;
    localparam logic [11:0] PAFS_OFF_FSEL_HIGH = 12'h010;
    localparam logic [11:0] PAFS_OFF_DATA_IN = 12'h014;
    localparam logic [11:0] PAFS_OFF_EDGE_RISE = 12'h018;
    localparam logic [11:0] PAFS_OFF_IRQ_STATUS = 12'h01c;
    localparam logic [11:0] PAFS_OFF_IRQ_CLEAR = 12'h020;
    localparam logic [11:0] PAFS_OFF_IRQ_ENABLE = 12'h024;

    // reset values, all six bits wide
    localparam logic [5:0] PAFS_RST_DATA_OUT = 6'h00;
    localparam logic [5:0] PAFS_RST_DIR = 6'h3f;
    localparam logic [5:0] PAFS_RST_AF_EN = 6'h04;
    localparam logic [5:0] PAFS_RST_FSEL = 6'h00;
    localparam logic [5:0] PAFS_RST_EDGE_RISE = 6'h00;
    localparam logic [5:0] PAFS_RST_IRQ = 6'h00;

    // pins whose interrupt edge is chosen; the rest fire on both edges
    localparam logic [5:0] PAFS_EDGE_CFG_MASK = 6'h0f;

    // width of the unused upper part of a 32-bit data word
    localparam int PAFS_PAD_W = 26;

    // function code: {function_select_low bit, function_select_high bit}
    typedef enum logic [1:0] {
        PAFS_SEL_00 = 2'b00,
        PAFS_SEL_01 = 2'b01,
        PAFS_SEL_10 = 2'b10,
        PAFS_SEL_11 = 2'b11
    } pafs_sel_t;

    // signals the on-chip peripherals hand to the mux
    typedef struct packed {
        logic timer_a_output;
        logic timer_b_output;
        logic uart_transmit_line;
        logic uart_driver_enable;
        logic comparator_output;
    } pafs_periph_out_t;

    // signals the mux hands back to the peripherals
    typedef struct packed {
        logic timer_a_input;
        logic timer_b_input;
        logic external_clock_input;
        logic external_reset_input;
        logic uart_clear_to_send;
        logic uart_receive_line;
    } pafs_periph_in_t;

    // idle value of the peripheral inputs when no pin feeds them
    localparam pafs_periph_in_t PAFS_PERIPH_IN_IDLE = 6'b000001;

endpackage

`default_nettype wire

// >>> hw/pafs_sync.sv
`default_nettype none

module pafs_sync
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);

    logic meta_ff; // first stage, read only by the second
    logic sync2_ff; // second stage
    logic sync3_ff; // third stage
    logic stable_ff; // accepted pin level
    logic nxt_stable;

    // a change is accepted only once stages two and three agree
    always_comb
    begin
        nxt_stable = (sync2_ff == sync3_ff) ? sync3_ff : stable_ff;
    end

    // the chain itself
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            stable_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= async_in;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
            stable_ff <= nxt_stable;
        end
    end

    // one-cycle edge pulses in the cycle the new level is accepted
    assign rise = (sync2_ff == sync3_ff) && sync3_ff && !stable_ff;
    assign fall = (sync2_ff == sync3_ff) && !sync3_ff && stable_ff;
    assign level = stable_ff;

endmodule // pafs_sync

`default_nettype wire

// >>> sim/pafs_chk.sv
`default_nettype none

// watches the pad mux ports; all checks on the one system clock
module pafs_chk
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] analog_en,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_ev; // a write taking effect at this edge
    assign wr_ev = psel && penable && pwrite;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_ready_const: assert property (pready)
        else $error("pready low");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_err_unmap: assert property (psel && penable && paddr > 12'h024
        |-> pslverr)
        else $error("unmapped access not refused");
    a_rd_upper: assert property (prdata[31:6] == 26'h0)
        else $error("prdata upper bits set");
    // read data must stand until the next setup phase
    a_rd_hold: assert property (psel && penable && !pwrite |=> $stable(prdata))
        else $error("prdata moved after read");
    a_ana_no_drive: assert property ((analog_en & pin_oe) == 6'h00)
        else $error("analog pad also driven");
    a_ana_out_low: assert property ((analog_en & pin_out) == 6'h00)
        else $error("analog pad carries output data");
    // only a clear or enable write may drop the request
    a_irq_fall: assert property ($fell(irq) |-> $past(wr_ev))
        else $error("irq fell without a write");
    // drive enables follow configuration only, one flop after the write
    a_oe_cause: assert property ($changed(pin_oe)
        |-> $past(wr_ev, 2) || !$past(rstn, 2))
        else $error("pin_oe changed without a write");
endmodule // pafs_chk

bind pafs_top pafs_chk u_chk (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe(pin_oe), .analog_en(analog_en), .irq(irq));

`default_nettype wire

// >>> sim/pafs_partner.sv
`default_nettype none

// peripherals and pads around the mux
module pafs_partner
    import pafs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire pafs_periph_out_t po_set,
    input wire logic [5:0] ext,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    output pafs_periph_out_t periph_out,
    output logic [5:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // peripherals launch their outputs from a flop, like real ones
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            periph_out <= '0;
        else
            periph_out <= po_set;
    end
    // pad level: block's driver wins where enabled, else the outside
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // pafs_partner

`default_nettype wire

// >>> sim/pafs_top_test.sv
`default_nettype none

// drives the mux over apb; checks pads, peripheral inputs and irq
module pafs_top_test
    import pafs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rstn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [5:0] pin_in, pin_out, pin_oe, analog_en, ext, eo, ou, pi;
    logic [4:0] p; // peripheral outputs, same order as the struct
    logic [1:0] c; // function code {low, high}
    pafs_periph_out_t periph_out, po_set;
    pafs_periph_in_t periph_in;
    int error_cnt, n_checks;
    logic [31:0] q[$]; // expected read data, oldest first

    pafs_top dut (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .analog_en(analog_en), .periph_out(periph_out),
        .periph_in(periph_in), .irq(irq));
    pafs_partner u_far (.clock(clock), .rstn(rstn), .po_set(po_set),
        .ext(ext), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_out(periph_out), .pin_in(pin_in));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task ck(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        n_checks++;
        if (seen !== ex)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, ex, seen);
        end
    endtask

    // one apb transfer; waits on pready, upper write bits are noise
    task go(input logic w, input logic [11:0] a, input logic [31:0] v);
        logic [31:0] r;
        r = $urandom;
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {r[31:6], v[5:0]};
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1)
            @(posedge clock);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] v);
        go(1'h1, a, v);
    endtask

    // the expectation is queued before the transfer starts
    task rd(input logic [11:0] a, input logic [31:0] ex);
        q.push_back(ex);
        go(1'h0, a, 32'h0);
    endtask

    task st(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // read data is taken at the access edge, oldest note first
    always @(posedge clock)
    begin
        if (psel && penable && !pwrite && pready)
            ck("prdata", prdata, q.size() ? q.pop_front() : 32'hdeadbeef);
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        conclude();
    end

    initial
    begin
        {psel, penable, pwrite, rstn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext = 6'h00;
        po_set = '0;
        error_cnt = 0;
        n_checks = 0;
        void'($urandom(56098));
        repeat (5) @(posedge clock);
        rstn <= 1'h1;
        rd(PAFS_OFF_DATA_OUT, 32'h00);
        rd(PAFS_OFF_DIR, 32'h3f);
        rd(PAFS_OFF_AF_EN, 32'h04);
        rd(PAFS_OFF_FSEL_LOW, 32'h00);
        rd(PAFS_OFF_FSEL_HIGH, 32'h00);
        rd(PAFS_OFF_EDGE_RISE, 32'h00);
        rd(PAFS_OFF_IRQ_STATUS, 32'h00);
        rd(PAFS_OFF_IRQ_CLEAR, 32'h00);
        rd(PAFS_OFF_IRQ_ENABLE, 32'h00);
        rd(12'h028, 32'h00);
        ck("oe rst", pin_oe, 32'h04);
        // pins 0 and 2 on rising edges, 1 and 3 on falling
        wr(PAFS_OFF_AF_EN, 32'h00);
        wr(PAFS_OFF_EDGE_RISE, 32'h05);
        wr(PAFS_OFF_IRQ_ENABLE, 32'h3f);
        @(posedge clock);
        ext <= 6'h3f;
        st(10);
        ck("irq", irq, 32'h1);
        rd(PAFS_OFF_IRQ_STATUS, 32'h35);
        wr(PAFS_OFF_IRQ_ENABLE, 32'h00);
        st(2);
        ck("irq", irq, 32'h0);
        rd(PAFS_OFF_IRQ_STATUS, 32'h35);
        wr(PAFS_OFF_IRQ_CLEAR, 32'h3f);
        @(posedge clock);
        ext <= 6'h00;
        st(10);
        rd(PAFS_OFF_IRQ_STATUS, 32'h3a);
        wr(PAFS_OFF_IRQ_ENABLE, 32'h02);
        st(2);
        ck("irq", irq, 32'h1);
        wr(PAFS_OFF_IRQ_CLEAR, 32'h02);
        st(2);
        ck("irq", irq, 32'h0);
        rd(PAFS_OFF_IRQ_STATUS, 32'h38);
        // plain port: pads follow data and direction
        for (int k = 0; k < 3; k++)
        begin
            d = $urandom;
            wr(PAFS_OFF_DIR, d);
            wr(PAFS_OFF_DATA_OUT, d >> 8);
            @(posedge clock);
            ext <= d[21:16];
            st(10);
            ck("gpio oe", pin_oe, {26'h0, ~d[5:0]});
            ck("gpio out", pin_out, d[13:8]);
            rd(PAFS_OFF_DATA_IN, (~d[5:0] & d[13:8]) | (d[5:0] & d[21:16]));
        end
        // every function code on all six pins, direction is noise
        for (int k = 0; k < 8; k++)
        begin
            c = k[1:0];
            d = $urandom;
            p = d[12:8];
            wr(PAFS_OFF_AF_EN, 32'h3f);
            wr(PAFS_OFF_FSEL_LOW, {26'h0, {6{c[1]}}});
            wr(PAFS_OFF_FSEL_HIGH, {26'h0, {6{c[0]}}});
            wr(PAFS_OFF_DIR, d);
            @(posedge clock);
            po_set <= pafs_periph_out_t'(p);
            ext <= d[21:16];
            st(10);
            case (c)
                2'h0: {eo, ou, pi} = {6'h26, p[2], 2'h0, p[1], p[4], 1'h0,
                    ext[0], 3'h0, ext[3], ext[4]};
                2'h1: {eo, ou, pi} = {6'h28, ~p[3], 1'h0, p[0], 3'h0,
                    3'h0, ext[2], 2'h1};
                2'h2: {eo, ou, pi} = {6'h04, 3'h0, p[3], 2'h0,
                    1'h0, ext[3], ext[1], 3'h1};
                default: {eo, ou, pi} = {6'h01, 5'h0, ~p[4], 6'h01};
            endcase
            ck("mux oe", pin_oe, eo);
            ck("mux out", pin_out, ou);
            ck("periph in", periph_in, pi);
            ck("analog", analog_en, c == 2'h3 ? 6'h3a : 6'h00);
            rd(PAFS_OFF_FSEL_HIGH, {26'h0, {6{c[0]}}});
        end
        st(2);
        ck("queue", q.size(), 32'h0);
        conclude();
    end
endmodule // pafs_top_test

`default_nettype wire
